/* sld_ctrl.v */
`timescale 1ns/100ps
`include "sld_defines.vh"

module sld_ctrl #(
  parameter OC_FILT_CYC = `SLD_OC_FILT_CYC, // overcurrent persistence in hclk cycles
  parameter CNT_W       = `SLD_OC_CNT_W     // filter counter width
) (
  input  wire        hclk,               // system clock, 200 MHz
  input  wire        hresetn,            // async reset, active low
  // ahb-lite slave
  input  wire        hsel,               // slave select
  input  wire [31:0] haddr,              // byte address
  input  wire [1:0]  htrans,             // transfer type
  input  wire        hwrite,             // write when high
  input  wire [2:0]  hsize,              // transfer size, word only
  input  wire [31:0] hwdata,             // write data
  input  wire        hready,             // bus ready
  output wire        hreadyout,          // slave ready
  output wire [31:0] hrdata,             // read data
  output wire        hresp,              // response, always okay
  // serial link pins
  input  wire        ser_clk,            // serial shift clock
  input  wire        ser_din,            // serial data in
  output wire        ser_dout,           // cascade data out
  input  wire        clear_in,           // clear, active high
  input  wire        load_in,            // latch load, active high
  input  wire        oe_rearm_n,         // output enable / fault rearm, active low
  // protection sense inputs
  input  wire [7:0]  oc_sense,           // per channel overcurrent comparator
  input  wire        temp_hot,           // die above thermal trip point
  input  wire        temp_cool,          // die below trip minus hysteresis
  input  wire        supply_low,         // supply below disable threshold
  input  wire        supply_ok,          // supply above release threshold
  // outputs
  output wire [7:0]  sink_on,            // channel sink drive, high sinks
  output wire        flag_o,             // fault flag pin level when driven
  output wire        flag_oe,            // fault flag pull-down enable
  output wire        low_supply_lockout  // lockout state
);

  localparam [CNT_W-1:0] OC_LAST = OC_FILT_CYC[CNT_W-1:0] - 1'b1;

  wire [`SLD_PIN_W-1:0] pin_raw;
  wire [`SLD_PIN_W-1:0] pin_s;
  wire                  ser_clk_s;
  wire                  ser_din_s;
  wire                  clear_s;
  wire                  load_s;
  wire                  oe_n_s;
  wire                  hot_s;
  wire                  cool_s;
  wire                  sup_low_s;
  wire                  sup_ok_s;
  wire [7:0]            oc_s;

  reg                   clk_prev_r;
  reg  [7:0]            shift_r;
  reg  [7:0]            latch_r;
  reg                   lock_r;
  reg                   lock_nxt;
  reg                   hot_r;
  reg                   hot_nxt;
  reg  [7:0]            trip_r;
  reg  [7:0]            trip_nxt;
  reg  [7:0]            trip_set;
  reg  [CNT_W-1:0]      oc_cnt_r [0:7];
  reg  [7:0]            sink_r;
  reg  [7:0]            sink_nxt;
  reg                   flag_oe_r;
  reg                   sw_dis_r;
  reg                   sw_rearm_r;
  reg                   ph_wr_r;
  reg  [`SLD_ADDR_W-1:0] ph_addr_r;
  reg  [31:0]           rdata_r;

  wire                  clk_rise;
  wire                  outs_off;
  wire                  rearm;
  wire                  bus_take;

  integer               i;
  integer               j;

  // pin order fixes the synchroniser reset pattern
  assign pin_raw = {oc_sense, supply_ok, supply_low, temp_cool, temp_hot,
                    oe_rearm_n, load_in, clear_in, ser_din, ser_clk};

  sld_sync #(
    .WIDTH     (`SLD_PIN_W),
    .RESET_VAL (`SLD_PIN_RST)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pin_raw),
    .q       (pin_s)
  );

  assign ser_clk_s = pin_s[0];
  assign ser_din_s = pin_s[1];
  assign clear_s   = pin_s[2];
  assign load_s    = pin_s[3];
  assign oe_n_s    = pin_s[4];
  assign hot_s     = pin_s[5];
  assign cool_s    = pin_s[6];
  assign sup_low_s = pin_s[7];
  assign sup_ok_s  = pin_s[8];
  assign oc_s      = pin_s[16:9];

  // data and clock share the same synchroniser delay, so setup at the pins
  // carries over; the sampler follows any serial clock with high and low
  // phases of at least two hclk periods, well above the minimum rate
  assign clk_rise = ser_clk_s & ~clk_prev_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_prev_r <= 1'b0;
      shift_r    <= 8'h00;
    end
    else
    begin
      clk_prev_r <= ser_clk_s;
      if (clk_rise)
      begin
        if (clear_s)
          shift_r <= 8'h00;
        else
          shift_r <= {shift_r[6:0], ser_din_s};
      end
    end
  end

  assign ser_dout = shift_r[7];

  // latches follow the shift register every cycle while load stays high;
  // the enable path never touches them
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latch_r <= 8'h00;
    else if (load_s)
      latch_r <= shift_r;
  end

  // both protection states hold between their two thresholds
  always @*
  begin
    lock_nxt = lock_r;
    if (sup_low_s)
      lock_nxt = 1'b1;
    else if (sup_ok_s)
      lock_nxt = 1'b0;
    hot_nxt = hot_r;
    if (hot_s)
      hot_nxt = 1'b1;
    else if (cool_s)
      hot_nxt = 1'b0;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_r <= `SLD_LOCK_RST;
      hot_r  <= 1'b0;
    end
    else
    begin
      lock_r <= lock_nxt;
      hot_r  <= hot_nxt;
    end
  end

  assign low_supply_lockout = lock_r;

  // lockout behaves as a held-high enable pin
  assign outs_off = oe_n_s | lock_r | hot_r | sw_dis_r;
  assign rearm    = oe_n_s | lock_r | sw_rearm_r;

  // counters only run while the channel is driven, so a tripped
  // channel cannot retrigger itself
  always @*
  begin
    for (i = 0; i < 8; i = i + 1)
      trip_set[i] = oc_s[i] & sink_r[i] & (oc_cnt_r[i] == OC_LAST);
    // a trip in the rearm cycle survives
    trip_nxt = (trip_r & ~{8{rearm}}) | trip_set;
    sink_nxt = latch_r & ~trip_nxt & ~{8{outs_off}};
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (j = 0; j < 8; j = j + 1)
        oc_cnt_r[j] <= {CNT_W{1'b0}};
      trip_r    <= 8'h00;
      sink_r    <= 8'h00;
      flag_oe_r <= 1'b0;
    end
    else
    begin
      for (j = 0; j < 8; j = j + 1)
      begin
        if (oc_s[j] & sink_r[j] & (oc_cnt_r[j] != OC_LAST))
          oc_cnt_r[j] <= oc_cnt_r[j] + 1'b1;
        else
          oc_cnt_r[j] <= {CNT_W{1'b0}};
      end
      trip_r    <= trip_nxt;
      sink_r    <= sink_nxt;
      flag_oe_r <= (|trip_nxt) | hot_nxt;
    end
  end

  assign sink_on = sink_r;
  assign flag_o  = 1'b0;
  assign flag_oe = flag_oe_r;

  // register read mux, shared by the address phase capture
  function [31:0] sld_rd_mux;
    input [`SLD_ADDR_W-1:0] ofs;
    begin
      sld_rd_mux = 32'h00000000;
      case (ofs)
        `SLD_OFS_CTRL:
          sld_rd_mux[`SLD_CTRL_DIS_BIT] = sw_dis_r;
        `SLD_OFS_STATUS:
        begin
          sld_rd_mux[`SLD_ST_TRIP_LSB+7:`SLD_ST_TRIP_LSB] = trip_r;
          sld_rd_mux[`SLD_ST_HOT_BIT]   = hot_r;
          sld_rd_mux[`SLD_ST_LOCK_BIT]  = lock_r;
          sld_rd_mux[`SLD_ST_FAULT_BIT] = flag_oe_r;
          sld_rd_mux[`SLD_ST_OFF_BIT]   = outs_off;
        end
        `SLD_OFS_DATA:
        begin
          sld_rd_mux[`SLD_DATA_LATCH_LSB+7:`SLD_DATA_LATCH_LSB] = latch_r;
          sld_rd_mux[`SLD_DATA_SHIFT_LSB+7:`SLD_DATA_SHIFT_LSB] = shift_r;
        end
        `SLD_OFS_OUT:
          sld_rd_mux[7:0] = sink_r;
        default:
          sld_rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  // zero wait state slave; hsize is not checked, word access assumed
  assign bus_take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_r    <= 1'b0;
      ph_addr_r  <= {`SLD_ADDR_W{1'b0}};
      rdata_r    <= 32'h00000000;
      sw_dis_r   <= `SLD_CTRL_RST;
      sw_rearm_r <= `SLD_CTRL_RST;
    end
    else
    begin
      ph_wr_r <= bus_take & hwrite;
      if (bus_take)
        ph_addr_r <= haddr[`SLD_ADDR_W-1:0];
      // read data is captured at the address phase so it stands all of the data phase
      if (bus_take & ~hwrite)
        rdata_r <= sld_rd_mux(haddr[`SLD_ADDR_W-1:0]);
      // rearm is a one-cycle pulse and reads back as zero
      sw_rearm_r <= 1'b0;
      if (ph_wr_r && (ph_addr_r == `SLD_OFS_CTRL))
      begin
        sw_dis_r   <= hwdata[`SLD_CTRL_DIS_BIT];
        sw_rearm_r <= hwdata[`SLD_CTRL_REARM_BIT];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hrdata    = rdata_r;
  assign hresp     = 1'b0;

endmodule // sld_ctrl

/* sld_defines.vh */
`ifndef SLD_DEFINES_VH
`define SLD_DEFINES_VH

// channel count
`define SLD_NCH            8

// clock and filter timing
`define SLD_CLK_PERIOD_NS  5
`define SLD_OC_FILT_NS     2000
`define SLD_OC_FILT_CYC    ((`SLD_OC_FILT_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_OC_CNT_W       9

// slowest serial rate the sampler must follow, in kHz
`define SLD_MIN_RATE_KHZ   3300

// register byte offsets (low eight address bits decoded)
`define SLD_ADDR_W         8
`define SLD_OFS_CTRL       8'h00
`define SLD_OFS_STATUS     8'h04
`define SLD_OFS_DATA       8'h08
`define SLD_OFS_OUT        8'h0C

// control register fields
`define SLD_CTRL_DIS_BIT   0
`define SLD_CTRL_REARM_BIT 1
`define SLD_CTRL_RST       1'b0

// status register fields
`define SLD_ST_TRIP_LSB    0
`define SLD_ST_HOT_BIT     8
`define SLD_ST_LOCK_BIT    9
`define SLD_ST_FAULT_BIT   10
`define SLD_ST_OFF_BIT     11

// data register fields
`define SLD_DATA_LATCH_LSB 0
`define SLD_DATA_SHIFT_LSB 8

// pin synchroniser layout and reset pattern (oe_rearm_n and supply_low idle high)
`define SLD_PIN_W          17
`define SLD_PIN_RST        17'h00090
`define SLD_LOCK_RST       1'b1

`endif

/* sld_sync.v */
`timescale 1ns/100ps
`include "sld_defines.vh"

module sld_sync #(
  parameter WIDTH                 = `SLD_PIN_W,
  parameter [WIDTH-1:0] RESET_VAL = `SLD_PIN_RST
) (
  input  wire             hclk,    // system clock
  input  wire             hresetn, // async reset, active low
  input  wire [WIDTH-1:0] d,       // asynchronous pin levels
  output wire [WIDTH-1:0] q        // levels in the hclk domain
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // stage1_r is read only by stage2_r to keep metastability contained
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end
    else
    begin
      stage1_r <= d;
      stage2_r <= stage1_r;
    end
  end

  assign q = stage2_r;

endmodule // sld_sync

/* sld_ctrl_asserts.sv */
`timescale 1ns/100ps
module sld_ctrl_asserts #(
  parameter OC_FILT_CYC = 400 // trip persistence in cycles
) (
  input wire       hclk,              // clock
  input wire       hresetn,           // reset, low
  input wire       ser_clk,           // serial clock pin
  input wire       ser_dout,          // cascade out
  input wire       clear_in,          // clear pin
  input wire       oe_rearm_n,        // enable, low
  input wire [7:0] oc_sense,          // overcurrent sense
  input wire       temp_hot,          // above trip
  input wire       temp_cool,         // below trip band
  input wire       supply_low,        // supply low
  input wire       supply_ok,         // supply good
  input wire [7:0] sink_on,           // channel drive
  input wire       flag_oe,           // flag pulled low
  input wire       low_supply_lockout // lockout state
);
  logic [15:0] oc_run_r;
  logic [15:0] oc_best_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // longest raw sense run since the last rearm; saturates for the full-length filter
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      oc_run_r  <= 16'h0000;
      oc_best_r <= 16'h0000;
    end
    else
    begin
      oc_run_r  <= (|oc_sense) ? oc_run_r + {15'h0000, oc_run_r != 16'hFFFF} : 16'h0000;
      oc_best_r <= oe_rearm_n ? 16'h0000 : ((oc_run_r > oc_best_r) ? oc_run_r : oc_best_r);
    end
  // pin levels reach the shifter three samples late: two sync stages plus the shift register update
  sequence clk_rise_s;
    $past(ser_clk, 3) && !$past(ser_clk, 4);
  endsequence
  sequence hot_run_s;
    temp_hot [*6];
  endsequence
  off_enable_a: assert property (oe_rearm_n [*6] |-> sink_on == 8'h00)
    else $error("outputs on while disabled");
  rearm_clear_a: assert property ((oe_rearm_n && temp_cool && !temp_hot) [*6] |-> !flag_oe)
    else $error("flag kept through rearm");
  lock_off_a: assert property (low_supply_lockout |=> sink_on == 8'h00)
    else $error("outputs on during lockout");
  lock_release_a: assert property ($fell(low_supply_lockout) |-> $past(supply_ok, 3) && !$past(supply_low, 3))
    else $error("lockout released without good supply");
  hot_off_a: assert property (hot_run_s |-> sink_on == 8'h00 && flag_oe)
    else $error("hot die left outputs on or flag off");
  oc_filter_a: assert property ($rose(flag_oe) |-> $past(temp_hot, 3) || oc_best_r >= OC_FILT_CYC)
    else $error("trip on a short current pulse");
  dout_step_a: assert property ($changed(ser_dout) |-> clk_rise_s)
    else $error("serial out moved without a clock rise");
  clear_zero_a: assert property ($changed(ser_dout) && $past(clear_in, 3) |-> !ser_dout)
    else $error("nonzero shifted while clear held");
endmodule // sld_ctrl_asserts

bind sld_ctrl sld_ctrl_asserts #(.OC_FILT_CYC(OC_FILT_CYC)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .ser_clk(ser_clk), .ser_dout(ser_dout), .clear_in(clear_in),
  .oe_rearm_n(oe_rearm_n), .oc_sense(oc_sense), .temp_hot(temp_hot), .temp_cool(temp_cool),
  .supply_low(supply_low), .supply_ok(supply_ok), .sink_on(sink_on), .flag_oe(flag_oe),
  .low_supply_lockout(low_supply_lockout));

/* sld_host_model.sv */
`timescale 1ns/100ps
module sld_host_model (
  output logic ser_clk,  // serial clock, idle low
  output logic ser_din,  // serial data
  output logic clear_in, // clear level
  output logic load_in   // latch load level
);
  initial
  begin
    ser_clk  = 1'b0;
    ser_din  = 1'b0;
    clear_in = 1'b0;
    load_in  = 1'b0;
  end
  // msb first so the first bit lands in the last stage; half sets the rate
  task automatic send(input logic [7:0] v, input logic clr, input int half);
    clear_in = clr;
    #7;
    for (int i = 7; i >= 0; i--)
    begin
      ser_din = v[i];
      #half ser_clk = 1'b1;
      #half ser_clk = 1'b0;
    end
    ser_din  = ~v[0];
    clear_in = 1'b0;
    #300 load_in = 1'b1;
    #125 load_in = 1'b0;
  endtask
endmodule // sld_host_model

/* serial_latched_sink_driver_ctrl_tb_top.sv */
`timescale 1ns/100ps
`include "sld_defines.vh"
module serial_latched_sink_driver_ctrl_tb_top;
  localparam int OC = 8;
  typedef struct {int code; logic [31:0] val;} sld_note_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        oe_rearm_n = 1'b1, temp_hot = 1'b0, temp_cool = 1'b1, supply_low = 1'b0, supply_ok = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  oc_sense = 8'h00, d;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_last;
  wire         hready, hreadyout, ser_clk, ser_din, clear_in, load_in, ser_dout, flag_oe, low_supply_lockout;
  wire         hresp, flag_o;
  wire  [7:0]  sink_on;
  wire  [31:0] hrdata;
  int          fail_count = 0, n_compared = 0, k;
  sld_note_t   q [$];
  sld_note_t   nt;
  event        look;
  string       nm [6] = '{"sink_on", "hrdata", "flag_oe", "ser_dout", "lockout", "bus_pins"};
  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;
  sld_host_model u_host (.ser_clk(ser_clk), .ser_din(ser_din), .clear_in(clear_in), .load_in(load_in));
  sld_ctrl #(.OC_FILT_CYC(OC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ser_clk(ser_clk), .ser_din(ser_din),
    .ser_dout(ser_dout), .clear_in(clear_in), .load_in(load_in), .oe_rearm_n(oe_rearm_n),
    .oc_sense(oc_sense), .temp_hot(temp_hot), .temp_cool(temp_cool), .supply_low(supply_low),
    .supply_ok(supply_ok), .sink_on(sink_on), .flag_o(flag_o), .flag_oe(flag_oe),
    .low_supply_lockout(low_supply_lockout));
  function automatic logic [31:0] obs(input int c);
    case (c)
      0: return {24'h000000, sink_on};
      1: return rd_last;
      2: return {31'h00000000, flag_oe};
      3: return {31'h00000000, ser_dout};
      4: return {31'h00000000, low_supply_lockout};
      default: return {29'h00000000, hreadyout, hresp, flag_o};
    endcase
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic note(input int c, input logic [31:0] v);
    q.push_back('{c, v});
    ->look;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_last = hrdata;
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(look)
    while (q.size() > 0)
    begin
      nt = q.pop_front();
      n_compared++;
      if (obs(nt.code) !== nt.val)
      begin
        fail_count++;
        $display("BAD %0s expected %0h seen %0h", nm[nt.code], nt.val, obs(nt.code));
      end
    end
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(3119));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wt(20);
    note(4, 32'h1);
    @(posedge hclk) supply_ok <= 1'b1;
    wt(8);
    note(4, 32'h0);
    @(posedge hclk) oe_rearm_n <= 1'b0;
    $display("test lockout done");
    for (int i = 0; i < 2; i++)
    begin
      d = 8'($urandom) | 8'h81;
      u_host.send(d, 1'b0, 40);
      wt(10);
      note(0, {24'h000000, d});
      note(3, {31'h00000000, d[7]});
      bus(1'b0, `SLD_OFS_DATA, 32'h0);
      note(1, {16'h0000, d, d});
    end
    @(posedge hclk) oe_rearm_n <= 1'b1;
    wt(8);
    note(0, 32'h0);
    bus(1'b0, `SLD_OFS_DATA, 32'h0);
    note(1, {16'h0000, d, d});
    @(posedge hclk) oe_rearm_n <= 1'b0;
    wt(8);
    note(0, {24'h000000, d});
    u_host.send(8'hFF, 1'b1, 40);
    wt(10);
    note(0, 32'h0);
    note(3, 32'h0);
    $display("test shift done");
    u_host.send(8'hFF, 1'b0, 40);
    k = $urandom_range(7);
    wt(10);
    // one cycle short of the filter: must not trip
    @(posedge hclk) oc_sense <= 8'h01 << k;
    repeat (OC - 1) @(posedge hclk);
    oc_sense <= 8'h00;
    wt(10);
    note(2, 32'h0);
    @(posedge hclk) oc_sense <= 8'h01 << k;
    repeat (OC + 6) @(posedge hclk);
    oc_sense <= 8'h00;
    wt(6);
    note(0, {24'h000000, ~(8'h01 << k)});
    note(2, 32'h1);
    bus(1'b0, `SLD_OFS_STATUS, 32'h0);
    note(1, 32'h00000400 | (32'h00000001 << k));
    bus(1'b0, `SLD_OFS_OUT, 32'h0);
    note(1, {24'h000000, ~(8'h01 << k)});
    @(posedge hclk) oe_rearm_n <= 1'b1;
    repeat (8) @(posedge hclk);
    oe_rearm_n <= 1'b0;
    wt(8);
    note(2, 32'h0);
    note(0, 32'hFF);
    // second trip, cleared by the software rearm pulse this time
    @(posedge hclk) oc_sense <= 8'h01 << k;
    repeat (OC + 6) @(posedge hclk);
    oc_sense <= 8'h00;
    wt(6);
    note(2, 32'h1);
    bus(1'b1, `SLD_OFS_CTRL, 32'h2);
    wt(4);
    note(2, 32'h0);
    note(0, 32'hFF);
    $display("test overcurrent done");
    @(posedge hclk) temp_cool <= 1'b0;
    temp_hot <= 1'b1;
    wt(8);
    note(0, 32'h0);
    bus(1'b0, `SLD_OFS_STATUS, 32'h0);
    note(1, 32'h00000D00);
    @(posedge hclk) temp_hot <= 1'b0;
    wt(8);
    note(0, 32'h0);
    @(posedge hclk) temp_cool <= 1'b1;
    wt(8);
    note(0, 32'hFF);
    @(posedge hclk) supply_low <= 1'b1;
    supply_ok <= 1'b0;
    wt(8);
    note(0, 32'h0);
    @(posedge hclk) supply_low <= 1'b0;
    supply_ok <= 1'b1;
    wt(8);
    note(0, 32'hFF);
    bus(1'b1, `SLD_OFS_CTRL, 32'h1);
    wt(4);
    note(0, 32'h0);
    bus(1'b0, `SLD_OFS_CTRL, 32'h0);
    note(1, 32'h1);
    bus(1'b1, `SLD_OFS_CTRL, 32'h0);
    bus(1'b0, 8'h44, 32'h0);
    note(1, 32'h0);
    note(5, 32'h00000004);
    $display("test protection done");
    wt(4);
    report_and_stop();
  end
endmodule // serial_latched_sink_driver_ctrl_tb_top
